// >>> include/lrp_pkg.sv
// Constants, types and carriers for the receive link event source
package lrp_pkg;

  // ==========================================================
  // Event codes
  localparam logic [7:0] LRP_EV_FLIT_TYPE = 8'h01;
  localparam logic [7:0] LRP_EV_BYPASS = 8'h09;
  localparam logic [7:0] LRP_EV_QUEUE_NE = 8'h0A;
  localparam logic [7:0] LRP_EV_FULL_POWER = 8'h0F;
  localparam logic [7:0] LRP_EV_HALF_WIDTH = 8'h10;
  localparam logic [7:0] LRP_EV_SHUTDOWN = 8'h12;
  localparam logic [7:0] LRP_EV_SHARED_CREDIT = 8'h1D;
  localparam logic [7:0] LRP_EV_NET_ZERO_CREDIT = 8'h1E;
  localparam logic [7:0] LRP_EV_NET_ONE_CREDIT = 8'h39;

  // ==========================================================
  // Message class bit positions in the credit unit mask
  localparam int LRP_CLS_DATA_RESP = 0;
  localparam int LRP_CLS_NONCOH_BYPASS = 1;
  localparam int LRP_CLS_NONCOH_STANDARD = 2;
  localparam int LRP_CLS_HOME = 3;
  localparam int LRP_CLS_SNOOP = 4;
  localparam int LRP_CLS_NONDATA_RESP = 5;

  // ==========================================================
  // Link geometry
  localparam int LRP_NUM_COUNTERS = 4;
  localparam int LRP_FLIT_INFO_BITS = 80;
  localparam int LRP_FULL_UNIT_BITS = 20;
  localparam int LRP_HALF_UNIT_BITS = 10;
  localparam logic [7:0] LRP_FULL_UNITS_PER_FLIT = 8'(LRP_FLIT_INFO_BITS / LRP_FULL_UNIT_BITS);
  localparam logic [7:0] LRP_HALF_UNITS_PER_FLIT = 8'(LRP_FLIT_INFO_BITS / LRP_HALF_UNIT_BITS);
  localparam logic [7:0] LRP_TRANSFERS_PER_CLK = 8'h08;
  localparam logic [7:0] LRP_FLIT_BITS_FIELD = 8'(LRP_FLIT_INFO_BITS);

  // ==========================================================
  // Register map (byte addresses)
  localparam int LRP_ADDR_W = 8;
  localparam logic [7:0] LRP_OFF_SEL0 = 8'h00;
  localparam logic [7:0] LRP_OFF_STATUS = 8'h10;
  localparam logic [7:0] LRP_OFF_INFO = 8'h14;

  // Event select field positions
  localparam int LRP_SEL_CODE_LSB = 0;
  localparam int LRP_SEL_UMASK_LSB = 8;
  localparam int LRP_SEL_EDGE_BIT = 18;
  localparam int LRP_SEL_EXTRA_BIT = 21;
  localparam int LRP_SEL_ENABLE_BIT = 22;

  // Status field positions
  localparam int LRP_ST_RX_PWR_LSB = 0;
  localparam int LRP_ST_TX_PWR_LSB = 2;
  localparam int LRP_ST_QUEUE_NE_BIT = 4;

  // Info field positions
  localparam int LRP_INFO_UNITS_LSB = 0;
  localparam int LRP_INFO_XFER_LSB = 8;
  localparam int LRP_INFO_FLITBITS_LSB = 16;

  localparam logic [31:0] LRP_SEL_RESET = 32'h0000_0000;
  localparam logic [1:0] LRP_RESP_OKAY = 2'h0;
  localparam logic [1:0] LRP_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LRP_PWR_FULL,
    LRP_PWR_HALF,
    LRP_PWR_SHUTDOWN,
    LRP_PWR_TRAINING
  } lrp_power_e;

  typedef enum logic [1:0] {
    LRP_NET_ZERO,
    LRP_NET_ONE,
    LRP_NET_SHARED,
    LRP_NET_NONE
  } lrp_net_e;

  typedef enum logic [1:0] {
    LRP_FLIT_IDLE,
    LRP_FLIT_DATA,
    LRP_FLIT_PROTOCOL,
    LRP_FLIT_OTHER
  } lrp_flit_e;

  typedef struct packed {
    logic enable;
    logic extra;
    logic edge_det;
    logic [7:0] umask;
    logic [7:0] code;
  } lrp_evsel_s;

  typedef struct packed {
    logic valid;
    lrp_net_e net;
    logic [2:0] msg_class;
  } lrp_credit_s;

  typedef struct packed {
    logic valid;
    lrp_flit_e ftype;
  } lrp_flit_s;

  typedef logic [LRP_NUM_COUNTERS-1:0][1:0] lrp_inc_t;

endpackage : lrp_pkg

// >>> logic/lrp_event_source.sv
// Receive link event source: event select registers and per-counter increments
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module lrp_event_source
  import lrp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [LRP_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [LRP_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Link layer datapath
  input wire lrp_power_e rx_power_state,
  input wire lrp_power_e tx_power_state,
  input wire logic rx_buffer_bypass,
  input wire lrp_credit_s [1:0] credit_slot,
  input wire logic [5:0] rx_queue_count,
  input wire lrp_flit_s [1:0] flit_slot,
  // Counter bank
  output lrp_inc_t cnt_inc
);

  // ==========================================================
  // Decoding helpers
  function automatic logic [2:0] sel_index(input logic [LRP_ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    if (addr[1:0] == 2'h0) begin
      if (addr >= LRP_OFF_SEL0 && addr < LRP_OFF_STATUS) begin
        idx = {1'b0, addr[3:2]};
      end else if (addr == LRP_OFF_STATUS) begin
        idx = 3'h4;
      end else if (addr == LRP_OFF_INFO) begin
        idx = 3'h5;
      end
    end
    return idx;
  endfunction : sel_index

  function automatic logic [31:0] sel_to_word(input lrp_evsel_s s);
    logic [31:0] w;
    w = 32'h0;
    w[LRP_SEL_CODE_LSB +: 8] = s.code;
    w[LRP_SEL_UMASK_LSB +: 8] = s.umask;
    w[LRP_SEL_EDGE_BIT] = s.edge_det;
    w[LRP_SEL_EXTRA_BIT] = s.extra;
    w[LRP_SEL_ENABLE_BIT] = s.enable;
    return w;
  endfunction : sel_to_word

  function automatic lrp_evsel_s word_to_sel(input logic [31:0] w);
    lrp_evsel_s s;
    s.code = w[LRP_SEL_CODE_LSB +: 8];
    s.umask = w[LRP_SEL_UMASK_LSB +: 8];
    s.edge_det = w[LRP_SEL_EDGE_BIT];
    s.extra = w[LRP_SEL_EXTRA_BIT];
    s.enable = w[LRP_SEL_ENABLE_BIT];
    return s;
  endfunction : word_to_sel

  // Raw per-cycle value of the selected event
  function automatic logic [1:0] event_value(
    input lrp_evsel_s s,
    input lrp_power_e rx_pwr,
    input logic bypass,
    input lrp_credit_s [1:0] cr,
    input logic queue_ne,
    input lrp_flit_s [1:0] fl
  );
    logic [1:0] v;
    logic [1:0] n0;
    logic [1:0] n1;
    logic [1:0] nf;
    logic any_shared;
    v = 2'h0;
    n0 = 2'h0;
    n1 = 2'h0;
    nf = 2'h0;
    any_shared = 1'b0;
    for (int k = 0; k < 2; k++) begin
      if (cr[k].valid && cr[k].net == LRP_NET_ZERO && s.umask[cr[k].msg_class]) begin
        n0 = n0 + 2'h1;
      end
      if (cr[k].valid && cr[k].net == LRP_NET_ONE && s.umask[cr[k].msg_class]) begin
        n1 = n1 + 2'h1;
      end
      if (cr[k].valid && cr[k].net == LRP_NET_SHARED) begin
        any_shared = 1'b1;
      end
      if (fl[k].valid && fl[k].ftype != LRP_FLIT_OTHER && s.umask[fl[k].ftype]) begin
        nf = nf + 2'h1;
      end
    end
    if (s.enable) begin
      if (!s.extra) begin
        case (s.code)
          LRP_EV_SHUTDOWN: v = {1'b0, rx_pwr == LRP_PWR_SHUTDOWN};
          LRP_EV_HALF_WIDTH: v = {1'b0, rx_pwr == LRP_PWR_HALF};
          LRP_EV_FULL_POWER: v = {1'b0, rx_pwr == LRP_PWR_FULL || rx_pwr == LRP_PWR_HALF};
          LRP_EV_BYPASS: v = {1'b0, bypass};
          LRP_EV_QUEUE_NE: v = {1'b0, queue_ne};
          LRP_EV_FLIT_TYPE: v = nf;
          default: v = 2'h0;
        endcase
      end else begin
        case (s.code)
          LRP_EV_NET_ZERO_CREDIT: v = n0;
          LRP_EV_NET_ONE_CREDIT: v = n1;
          LRP_EV_SHARED_CREDIT: v = {1'b0, any_shared};
          default: v = 2'h0;
        endcase
      end
    end
    return v;
  endfunction : event_value

  // ==========================================================
  // Registers
  lrp_evsel_s sel [LRP_NUM_COUNTERS];
  logic [LRP_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic queue_ne;
  logic do_write;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [31:0] rd_word;
  logic [7:0] units_per_flit;

  assign queue_ne = |rx_queue_count;
  assign do_write = !s_awready && !s_wready && !s_bvalid;
  assign wr_idx = sel_index(aw_addr);
  assign rd_idx = sel_index(s_araddr);

  // Transfer units per flit follow the receive width
  always_comb begin
    units_per_flit = LRP_FULL_UNITS_PER_FLIT;
    if (rx_power_state == LRP_PWR_HALF) begin
      units_per_flit = LRP_HALF_UNITS_PER_FLIT;
    end
  end

  always_comb begin
    rd_word = 32'h0;
    if (rd_idx < 3'h4) begin
      rd_word = sel_to_word(sel[rd_idx[1:0]]);
    end else if (rd_idx == 3'h4) begin
      rd_word[LRP_ST_RX_PWR_LSB +: 2] = rx_power_state;
      rd_word[LRP_ST_TX_PWR_LSB +: 2] = tx_power_state;
      rd_word[LRP_ST_QUEUE_NE_BIT] = queue_ne;
    end else if (rd_idx == 3'h5) begin
      rd_word[LRP_INFO_UNITS_LSB +: 8] = units_per_flit;
      rd_word[LRP_INFO_XFER_LSB +: 8] = LRP_TRANSFERS_PER_CLK;
      rd_word[LRP_INFO_FLITBITS_LSB +: 8] = LRP_FLIT_BITS_FIELD;
    end
  end

  // ==========================================================
  // Write channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_awvalid && s_awready) begin
      s_awready <= 1'b0;
      aw_addr <= s_awaddr;
    end else if (do_write) begin
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_wready <= 1'b1;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      s_wready <= 1'b0;
      w_data <= s_wdata;
      w_strb <= s_wstrb;
    end else if (do_write) begin
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_bvalid <= 1'b0;
      s_bresp <= LRP_RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp <= (wr_idx < 3'h6) ? LRP_RESP_OKAY : LRP_RESP_SLVERR;
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Event select registers with byte strobes; status and info ignore writes
  generate
    for (genvar g = 0; g < LRP_NUM_COUNTERS; g++) begin : g_sel
      logic [31:0] next_word;
      always_comb begin
        next_word = sel_to_word(sel[g]);
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            next_word[b*8 +: 8] = w_data[b*8 +: 8];
          end
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sel[g] <= word_to_sel(LRP_SEL_RESET);
        end else if (do_write && wr_idx == 3'(g)) begin
          sel[g] <= word_to_sel(next_word);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= LRP_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= (rd_idx < 3'h6) ? LRP_RESP_OKAY : LRP_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Per-counter increments
  generate
    for (genvar c = 0; c < LRP_NUM_COUNTERS; c++) begin : g_cnt
      logic [1:0] raw;
      logic prev_active;
      assign raw = event_value(sel[c], rx_power_state, rx_buffer_bypass, credit_slot, queue_ne, flit_slot);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          prev_active <= 1'b0;
        end else begin
          prev_active <= |raw;
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_inc[c] <= 2'h0;
        end else if (sel[c].edge_det) begin
          cnt_inc[c] <= {1'b0, (|raw) && !prev_active};
        end else begin
          cnt_inc[c] <= raw;
        end
      end
    end
  endgenerate

endmodule : lrp_event_source

`default_nettype wire

// >>> tb/lrp_event_source_props.sv
// Port checker for the receive link event source
`timescale 1ns/100ps
`default_nettype none
module lrp_event_source_props
  import lrp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Counter bank
  input wire lrp_inc_t cnt_inc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ====
  // Properties
  property p_inc_max; cnt_inc[0] != 2'h3 && cnt_inc[1] != 2'h3 && cnt_inc[2] != 2'h3 && cnt_inc[3] != 2'h3; endproperty
  a_inc_max: assert property (p_inc_max) else $error("increment above two");
  property p_rd_lat; s_arvalid && s_arready |=> s_rvalid && !s_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_rd_drop; s_rvalid && s_rready |=> !s_rvalid && s_arready; endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read answer kept");
  property p_ar_block; s_rvalid |-> !s_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_wr_lat; s_awvalid && s_awready && s_wvalid && s_wready |=> !s_awready && !s_wready ##1 s_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_rd_err; s_rvalid && s_rresp == LRP_RESP_SLVERR |-> s_rdata == 32'h0000_0000; endproperty
  a_rd_err: assert property (p_rd_err) else $error("refused read returns data");
  c_rd_err: cover property (s_rvalid && s_rresp == LRP_RESP_SLVERR);
  c_inc_two: cover property (cnt_inc[0] == 2'h2);
  c_wr_done: cover property (s_bvalid && s_bready);
endmodule : lrp_event_source_props

bind lrp_event_source lrp_event_source_props u_props (
  .clk(clk), .rstn(rstn), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .cnt_inc(cnt_inc)
);
`default_nettype wire

// >>> tb/lrp_counter_bank.sv
// Counter bank model that accumulates the event increments
`timescale 1ns/100ps
`default_nettype none
module lrp_counter_bank
  import lrp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Increments and totals
  input wire lrp_inc_t inc,
  output logic [LRP_NUM_COUNTERS-1:0][31:0] count
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      for (int i = 0; i < LRP_NUM_COUNTERS; i++) count[i] <= count[i] + 32'(inc[i]);
    end
  end
endmodule : lrp_counter_bank
`default_nettype wire

// >>> tb/lrp_event_source_tb_top.sv
// Self-checking bench for the receive link event source
`timescale 1ns/100ps
`default_nettype none
module lrp_event_source_tb_top
  import lrp_pkg::*;
;
  logic clk, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, rx_buffer_bypass, p_byp, chk_on, chk_q;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, base [4];
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic [5:0] rx_queue_count, p_qc;
  lrp_power_e rx_power_state, tx_power_state, p_rx;
  lrp_credit_s [1:0] credit_slot, p_cr;
  lrp_flit_s [1:0] flit_slot, p_fl;
  lrp_inc_t cnt_inc;
  logic [3:0][31:0] count;
  lrp_evsel_s msel [4];
  int err_total, checks_done, cyc, tot [4], mprev [4];
  integer seed;
  // No edge-detected half-width select, since shutdown cycles occur
  localparam logic [31:0] TAB [16] = '{32'h0040_0012, 32'h0040_0010, 32'h0040_000F, 32'h0040_0009,
    32'h0040_000A, 32'h0040_0101, 32'h0040_0201, 32'h0040_0401, 32'h0040_0701, 32'h0060_3F1E,
    32'h0060_2A39, 32'h0060_001D, 32'h0044_0012, 32'h0040_3F1E, 32'h0000_0012, 32'h0040_0014};

  lrp_event_source u_dut (.clk(clk), .rstn(rstn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rx_power_state(rx_power_state), .tx_power_state(tx_power_state), .rx_buffer_bypass(rx_buffer_bypass),
    .credit_slot(credit_slot), .rx_queue_count(rx_queue_count), .flit_slot(flit_slot), .cnt_inc(cnt_inc));
  lrp_counter_bank u_bank (.clk(clk), .rstn(rstn), .inc(cnt_inc), .count(count));

  // ====
  // Checking and bus tasks
  task automatic stop_test;
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic fa, fw, fb;
    logic [1:0] rs;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      fa = s_awready && s_awvalid;
      fw = s_wready && s_wvalid;
      fb = s_bvalid;
      rs = s_bresp;
      @(posedge clk);
      if (fa) s_awvalid <= 1'b0;
      if (fw) s_wvalid <= 1'b0;
    end while (!fb);
    chk(32'(rs), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic fa, fr;
    logic [31:0] dt;
    logic [1:0] rs;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      fa = s_arready && s_arvalid;
      fr = s_rvalid;
      dt = s_rdata;
      rs = s_rresp;
      @(posedge clk);
      if (fa) s_arvalid <= 1'b0;
    end while (!fr);
    chk(dt, ed);
    chk(32'(rs), 32'(er));
  endtask : rd

  task automatic quiet;
    rx_power_state <= LRP_PWR_TRAINING;
    rx_buffer_bypass <= 1'b0;
    credit_slot <= '0;
    flit_slot <= '0;
    rx_queue_count <= 6'h00;
  endtask : quiet

  task automatic drive_rand;
    logic [31:0] v, c;
    v = $random(seed);
    c = $random(seed);
    if (v[1:0] == 2'h0) rx_power_state <= lrp_power_e'(v[3:2]);
    tx_power_state <= lrp_power_e'(v[5:4]);
    rx_buffer_bypass <= v[6];
    rx_queue_count <= v[8] ? v[14:9] : 6'h00;
    credit_slot[0] <= '{v[16], lrp_net_e'(c[1:0]), 3'(c[11:8] % 4'h6)};
    credit_slot[1] <= '{v[17], lrp_net_e'(c[3:2]), 3'(c[15:12] % 4'h6)};
    flit_slot[0] <= '{v[18], lrp_flit_e'(c[17:16])};
    flit_slot[1] <= '{v[19], lrp_flit_e'(c[19:18])};
  endtask : drive_rand

  // ====
  // Reference event model
  function automatic int raw_of(lrp_evsel_s s);
    int r;
    r = 0;
    for (int k = 0; k < 2; k++) begin
      if (s.extra && p_cr[k].valid && s.umask[p_cr[k].msg_class] && ((s.code == LRP_EV_NET_ZERO_CREDIT &&
          p_cr[k].net == LRP_NET_ZERO) || (s.code == LRP_EV_NET_ONE_CREDIT && p_cr[k].net == LRP_NET_ONE))) r++;
      if (!s.extra && s.code == LRP_EV_FLIT_TYPE && p_fl[k].valid && p_fl[k].ftype != LRP_FLIT_OTHER &&
          s.umask[p_fl[k].ftype]) r++;
      if (s.extra && s.code == LRP_EV_SHARED_CREDIT && p_cr[k].valid && p_cr[k].net == LRP_NET_SHARED) r = 1;
    end
    if (!s.extra) begin
      case (s.code)
        LRP_EV_SHUTDOWN: r = int'(p_rx == LRP_PWR_SHUTDOWN);
        LRP_EV_HALF_WIDTH: r = int'(p_rx == LRP_PWR_HALF);
        LRP_EV_FULL_POWER: r = int'(p_rx == LRP_PWR_FULL || p_rx == LRP_PWR_HALF);
        LRP_EV_BYPASS: r = int'(p_byp);
        LRP_EV_QUEUE_NE: r = int'(p_qc != 6'h00);
        default: ;
      endcase
    end
    return s.enable ? r : 0;
  endfunction : raw_of

  always @(negedge clk) begin
    int r, e;
    for (int i = 0; i < 4; i++) begin
      r = raw_of(msel[i]);
      e = msel[i].edge_det ? int'(r != 0 && mprev[i] == 0) : r;
      mprev[i] = r;
      if (chk_on && !chk_q) begin
        base[i] = count[i];
        tot[i] = 0;
      end
      if (chk_on) chk(32'(cnt_inc[i]), 32'(e));
      if (chk_on) tot[i] += e;
      if (!chk_on && chk_q) chk(count[i] - base[i], 32'(tot[i]));
    end
    chk_q = chk_on;
    p_rx = rx_power_state;
    p_byp = rx_buffer_bypass;
    p_cr = credit_slot;
    p_qc = rx_queue_count;
    p_fl = flit_slot;
  end

  // ====
  // Clock, timeout and main sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      stop_test;
    end
  end

  initial begin
    logic [31:0] w;
    seed = 32'h862e;
    for (int i = 0; i < 4; i++) msel[i] = '0;
    chk_on <= 1'b0;
    rstn <= 1'b0;
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    s_arvalid <= 1'b0;
    s_bready <= 1'b1;
    s_rready <= 1'b1;
    s_awaddr <= 8'h00;
    s_araddr <= 8'h00;
    s_wdata <= 32'h0;
    s_wstrb <= 4'hF;
    tx_power_state <= LRP_PWR_FULL;
    quiet;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), LRP_SEL_RESET, LRP_RESP_OKAY);
    rd(8'h40, 32'h0, LRP_RESP_SLVERR);
    wr(8'h18, 32'h1, LRP_RESP_SLVERR);
    wr(8'h02, 32'h1, LRP_RESP_SLVERR);
    rd(8'h00, LRP_SEL_RESET, LRP_RESP_OKAY);
    s_wstrb <= 4'h2;
    wr(8'h00, 32'hFFFF_FFFF, LRP_RESP_OKAY);
    rd(8'h00, 32'h0000_FF00, LRP_RESP_OKAY);
    s_wstrb <= 4'hC;
    wr(8'h00, 32'hFFFF_FFFF, LRP_RESP_OKAY);
    rd(8'h00, 32'h0064_FF00, LRP_RESP_OKAY);
    s_wstrb <= 4'hF;
    wr(LRP_OFF_STATUS, 32'hFFFF_FFFF, LRP_RESP_OKAY);
    wr(LRP_OFF_INFO, 32'hFFFF_FFFF, LRP_RESP_OKAY);
    rx_power_state <= LRP_PWR_HALF;
    tx_power_state <= LRP_PWR_SHUTDOWN;
    rx_queue_count <= 6'h03;
    rd(LRP_OFF_STATUS, {27'h0, 1'b1, LRP_PWR_SHUTDOWN, LRP_PWR_HALF}, LRP_RESP_OKAY);
    rd(LRP_OFF_INFO, 32'h0050_0808, LRP_RESP_OKAY);
    rx_power_state <= LRP_PWR_FULL;
    rd(LRP_OFF_INFO, 32'h0050_0804, LRP_RESP_OKAY);
    for (int r = 0; r < 16; r++) begin
      quiet;
      chk_on <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        w = TAB[(r + 4 * i) % 16];
        wr(8'(4 * i), w, LRP_RESP_OKAY);
        msel[i] = '{w[22], w[21], w[18], w[15:8], w[7:0]};
      end
      repeat (2) @(posedge clk);
      chk_on <= 1'b1;
      repeat (40) begin
        @(posedge clk);
        drive_rand;
      end
      @(posedge clk);
      quiet;
      @(posedge clk);
    end
    quiet;
    chk_on <= 1'b0;
    repeat (2) @(posedge clk);
    stop_test;
  end
endmodule : lrp_event_source_tb_top
`default_nettype wire
